// [common/emgc_regs.svh]
// Purpose: Offsets, field positions and fixed values of the emulator core.
// Assumes: Included by emgc_pkg, emgc_ea and emgc_core.
// Notes:   Register offsets index 16-bit words on the plain register port.
`ifndef EMGC_REGS_SVH
`define EMGC_REGS_SVH
`define EMGC_WORD_W      16
`define EMGC_SLOTS       8
`define EMGC_PC_SLOT     3'h6
`define EMGC_AC_TOP      2'h3
`define EMGC_IO_BASE     16'hfe00
`define EMGC_DISPLACEMENT_FIELD_LIMIT  8'h80
`define EMGC_DISPLACEMENT_FIELD_EXT    16'hff00
`define EMGC_OP_JUMP     2'h0
`define EMGC_OP_LOAD     2'h1
`define EMGC_OP_STORE    2'h2
`define EMGC_J_JMP       2'h0
`define EMGC_J_JSR       2'h1
`define EMGC_IDX_PAGE0   2'h0
`define EMGC_IDX_REL     2'h1
`define EMGC_IDX_BASE2   2'h2
`define EMGC_IDX_BASE3   2'h3
`define EMGC_TASKS       16
`define EMGC_MPC_W       12
`define EMGC_BANK_W      2
`define EMGC_F_GROUP     15
`define EMGC_F_OP_HI     14
`define EMGC_F_OP_LO     13
`define EMGC_F_ACC_HI    12
`define EMGC_F_ACC_LO    11
`define EMGC_F_IND       10
`define EMGC_F_IDX_HI    9
`define EMGC_F_IDX_LO    8
`define EMGC_F_DISPLACEMENT_FIELD_HI   7
`define EMGC_REG_CTRL    4'h0
`define EMGC_REG_STAT    4'h1
`define EMGC_REG_PC      4'h2
`define EMGC_REG_CARRY   4'h3
`define EMGC_REG_AC0     4'h4
`define EMGC_REG_AC3     4'h7
`define EMGC_REG_MPC     4'h8
`define EMGC_CTRL_RUN    0
`define EMGC_CTRL_BANK   2:1
`define EMGC_CTRL_SEL    7:4
`define EMGC_STAT_ACTIVE 0
`define EMGC_STAT_UNSUP  1
`define EMGC_STAT_IO     2
`define EMGC_STAT_IDLE   3
`define EMGC_CTRL_RST    16'h0000
`define EMGC_WORD_RST    16'h0000
`endif

// [common/emgc_pkg.sv]
// Purpose: Types and shared decode helpers of the emulator core.
// Assumes: Constants come from emgc_regs.svh.
// Notes:   Functions here are used by the core, except emgc_widen, which only the address unit uses.
package emgc_pkg;
`include "emgc_regs.svh"
    typedef logic [`EMGC_WORD_W-1:0] emgc_word_t;
    typedef logic [2:0]              emgc_slot_t;
    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_FETCH_W, S_DECODE, S_INDIR_W, S_EXEC, S_EXEC_W
    } emgc_state_e;

    function automatic emgc_word_t emgc_widen(input logic [7:0] d);
        emgc_word_t w;
        w = {8'h00, d};
        if (d > `EMGC_DISPLACEMENT_FIELD_LIMIT) begin
            w = w + `EMGC_DISPLACEMENT_FIELD_EXT;
        end
        return w;
    endfunction

    function automatic emgc_slot_t emgc_ac_slot(input logic [1:0] n);
        logic [1:0] s;
        s = `EMGC_AC_TOP - n;
        return {1'b0, s};
    endfunction

    function automatic logic emgc_is_io(input emgc_word_t a);
        return a >= `EMGC_IO_BASE;
    endfunction
endpackage

// [common/emgc_ea_if.sv]
// Purpose: Carries instruction and base values to the address unit.
// Assumes: Purely combinational path inside one clock domain.
// Notes:   The core samples ea before any register of the instruction moves.
`timescale 1ns/10ps
interface emgc_ea_if;
    import emgc_pkg::*;
    emgc_word_t instr;
    emgc_word_t pc;
    emgc_word_t ac2;
    emgc_word_t ac3;
    emgc_word_t ea;
    logic       indirect;
    modport core (output instr, output pc, output ac2, output ac3,
                  input ea, input indirect);
    modport unit (input instr, input pc, input ac2, input ac3,
                  output ea, output indirect);
endinterface

// [rtl/emgc_ea.sv]
// Purpose: Forms the base operand location from index and displacement.
// Assumes: Indirection itself is done by the core with one memory read.
// Notes:   Sums wrap modulo 64K words.
`timescale 1ns/10ps
`include "emgc_regs.svh"
module emgc_ea (
    emgc_ea_if.unit eaif
);
    import emgc_pkg::*;
    logic [7:0] displacement_field;

    always_comb begin
        displacement_field = eaif.instr[`EMGC_F_DISPLACEMENT_FIELD_HI:0];
        eaif.indirect = eaif.instr[`EMGC_F_IND];
        unique case (eaif.instr[`EMGC_F_IDX_HI:`EMGC_F_IDX_LO])
            `EMGC_IDX_PAGE0: eaif.ea = {8'h00, displacement_field};
            `EMGC_IDX_REL:   eaif.ea = emgc_widen(displacement_field) + eaif.pc;
            `EMGC_IDX_BASE2: eaif.ea = emgc_widen(displacement_field) + eaif.ac2;
            `EMGC_IDX_BASE3: eaif.ea = emgc_widen(displacement_field) + eaif.ac3;
        endcase
    end
endmodule // emgc_ea

// [rtl/emgc_core.sv]
// Purpose: Emulator task state and memory-group instruction execution.
// Assumes: Memory answers a held read or write strobe with a one-cycle ack.
// Notes:   Software may load the state only while the core is stopped.
// What this block does
// - Program counter holds next instruction address.
// - Program counter lives in scratch slot six.
// - Four sixteen-bit accumulators, indices zero to three.
// - Accumulators map reversed onto slots three to zero.
// - One carry flag held in its own flop.
// - Memory is 64K words, sixteen-bit addresses.
// - Addresses from fe00 upward form the I/O region.
// - Bank select extends memory to four 64K banks.
// - Displacement above 80 hex widened with ff00, except in page zero.
// - Index picks page zero, PC, AC2 or AC3.
// - Indirection replaces location exactly once.
// - Operand location settles before any state changes.
// - Target field directly selects the accumulator.
// - Load op reads memory into the accumulator.
// - Store op writes the accumulator to memory.
// - Emulator always requests wakeup, lowest priority.
// - Reset cycle loads each task address with number.
// - Subroutine call links into AC3, jumps to location.
`timescale 1ns/10ps
`include "emgc_regs.svh"
module emgc_core #(
    parameter int TASKS  = `EMGC_TASKS,
    parameter int MPC_W  = `EMGC_MPC_W,
    parameter int BANK_W = `EMGC_BANK_W
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    input  wire logic [3:0]         i_reg_addr,
    input  wire emgc_pkg::emgc_word_t i_reg_wdata,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    output emgc_pkg::emgc_word_t    o_reg_rdata,
    output logic                    o_mem_rd,
    output logic                    o_mem_wr,
    output emgc_pkg::emgc_word_t    o_mem_addr,
    output emgc_pkg::emgc_word_t    o_mem_wdata,
    output logic [BANK_W-1:0]       o_mem_bank,
    output logic                    o_mem_io,
    input  wire logic               i_mem_ack,
    input  wire emgc_pkg::emgc_word_t i_mem_rdata,
    input  wire logic [TASKS-1:1]   i_other_wake,
    input  wire logic               i_reset_cycle,
    output logic                    o_emu_wake,
    output logic                    o_emu_active,
    output logic [MPC_W-1:0]        o_emu_mpc
);
    import emgc_pkg::*;

    emgc_state_e      state;
    emgc_word_t       instr;
    emgc_word_t       ea;
    emgc_word_t       slot [`EMGC_SLOTS];
    emgc_word_t       ctrl;
    logic             carry;
    logic             unsup_seen;
    logic [MPC_W-1:0] task_micro_address [TASKS];
    emgc_ea_if        eaif ();

    logic       run;
    logic [1:0] op;
    logic [1:0] acc;
    logic       is_mem;
    logic       is_jump;
    logic       do_jmp;
    logic       do_jsr;
    logic       uses_ea;
    logic       preempt;
    logic       fetch_go;
    logic       finish;
    logic       ld_done;
    logic       launch;
    logic       sw_load;
    logic       unsup_set;
    emgc_word_t pc;
    emgc_word_t next_mem_addr;
    emgc_word_t next_rdata;
    logic       next_active;

    emgc_ea u_ea (
        .eaif (eaif.unit)
    );

    always_comb begin
        run      = ctrl[`EMGC_CTRL_RUN];
        pc       = slot[`EMGC_PC_SLOT];
        op       = instr[`EMGC_F_OP_HI:`EMGC_F_OP_LO];
        acc      = instr[`EMGC_F_ACC_HI:`EMGC_F_ACC_LO];
        is_mem   = !instr[`EMGC_F_GROUP] &&
                   (op == `EMGC_OP_LOAD || op == `EMGC_OP_STORE);
        is_jump  = !instr[`EMGC_F_GROUP] && op == `EMGC_OP_JUMP;
        do_jmp   = is_jump && acc == `EMGC_J_JMP;
        do_jsr   = is_jump && acc == `EMGC_J_JSR;
        uses_ea  = is_mem || do_jmp || do_jsr;
        preempt  = |i_other_wake;
        fetch_go = state == S_FETCH && run && !preempt;
        finish   = (state == S_EXEC && !is_mem) ||
                   (state == S_EXEC_W && i_mem_ack);
        ld_done  = state == S_EXEC_W && i_mem_ack &&
                   op == `EMGC_OP_LOAD;
        launch   = fetch_go ||
                   (state == S_DECODE && uses_ea && eaif.indirect) ||
                   (state == S_EXEC && is_mem);
        sw_load  = i_reg_wr && state == S_IDLE;
        unsup_set = state == S_DECODE && !uses_ea;
        next_active = state != S_IDLE && !(state == S_FETCH && preempt);
        unique case (state)
            S_FETCH:  next_mem_addr = pc;
            S_DECODE: next_mem_addr = eaif.ea;
            default:  next_mem_addr = ea;
        endcase
    end

    // The address unit sees the state as it stood when the fetch ended.
    assign eaif.instr = instr;
    assign eaif.pc    = pc;
    assign eaif.ac2   = slot[emgc_ac_slot(2'h2)];
    assign eaif.ac3   = slot[emgc_ac_slot(2'h3)];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= S_IDLE;
            instr <= `EMGC_WORD_RST;
            ea    <= `EMGC_WORD_RST;
        end else if (i_ce) begin
            unique case (state)
                S_IDLE: begin
                    if (run) begin
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    // Switching is only allowed between instructions.
                    if (!run) begin
                        state <= S_IDLE;
                    end else if (!preempt) begin
                        state <= S_FETCH_W;
                    end
                end
                S_FETCH_W: begin
                    if (i_mem_ack) begin
                        instr <= i_mem_rdata;
                        state <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    ea <= eaif.ea;
                    if (uses_ea && eaif.indirect) begin
                        state <= S_INDIR_W;
                    end else begin
                        state <= S_EXEC;
                    end
                end
                S_INDIR_W: begin
                    if (i_mem_ack) begin
                        ea    <= i_mem_rdata;
                        state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    state <= is_mem ? S_EXEC_W : S_FETCH;
                end
                S_EXEC_W: begin
                    if (i_mem_ack) begin
                        state <= S_FETCH;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_addr  <= `EMGC_WORD_RST;
            o_mem_wdata <= `EMGC_WORD_RST;
            o_mem_bank  <= '0;
            o_mem_io    <= 1'b0;
        end else if (i_ce) begin
            if (launch) begin
                o_mem_addr  <= next_mem_addr;
                o_mem_io    <= emgc_is_io(next_mem_addr);
                // The I/O region is never banked, so every bank sees it.
                o_mem_bank  <= emgc_is_io(next_mem_addr) ? '0 :
                               BANK_W'(ctrl[`EMGC_CTRL_BANK]);
                o_mem_rd    <= !(state == S_EXEC && op == `EMGC_OP_STORE);
                o_mem_wr    <= state == S_EXEC && op == `EMGC_OP_STORE;
                o_mem_wdata <= slot[emgc_ac_slot(acc)];
            end else if (i_mem_ack) begin
                o_mem_rd <= 1'b0;
                o_mem_wr <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int i = 0; i < `EMGC_SLOTS; i++) begin
                slot[i] <= `EMGC_WORD_RST;
            end
        end else if (i_ce) begin
            if (sw_load && i_reg_addr == `EMGC_REG_PC) begin
                slot[`EMGC_PC_SLOT] <= i_reg_wdata;
            end
            if (sw_load && i_reg_addr >= `EMGC_REG_AC0 &&
                i_reg_addr <= `EMGC_REG_AC3) begin
                slot[emgc_ac_slot(i_reg_addr[1:0])] <= i_reg_wdata;
            end
            if (ld_done) begin
                slot[emgc_ac_slot(acc)] <= i_mem_rdata;
            end
            if (finish) begin
                if (do_jsr) begin
                    slot[emgc_ac_slot(2'h3)] <= pc + 16'h0001;
                    slot[`EMGC_PC_SLOT]      <= ea;
                end else if (do_jmp) begin
                    slot[`EMGC_PC_SLOT] <= ea;
                end else begin
                    slot[`EMGC_PC_SLOT] <= pc + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            carry <= 1'b0;
        end else if (i_ce && sw_load && i_reg_addr == `EMGC_REG_CARRY) begin
            carry <= i_reg_wdata[0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl       <= `EMGC_CTRL_RST;
            unsup_seen <= 1'b0;
        end else if (i_ce) begin
            if (i_reg_wr && i_reg_addr == `EMGC_REG_CTRL) begin
                ctrl <= i_reg_wdata;
            end
            // A new event beats a clear in the same cycle.
            if (unsup_set) begin
                unsup_seen <= 1'b1;
            end else if (i_reg_wr && i_reg_addr == `EMGC_REG_STAT &&
                         i_reg_wdata[`EMGC_STAT_UNSUP]) begin
                unsup_seen <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int t = 0; t < TASKS; t++) begin
                task_micro_address[t] <= MPC_W'(t);
            end
            o_emu_wake   <= 1'b1;
            o_emu_active <= 1'b0;
        end else if (i_ce) begin
            if (i_reset_cycle) begin
                for (int t = 0; t < TASKS; t++) begin
                    task_micro_address[t] <= MPC_W'(t);
                end
            end
            o_emu_wake   <= 1'b1;
            o_emu_active <= next_active;
        end
    end

    assign o_emu_mpc = task_micro_address[0];

    always_comb begin
        next_rdata = `EMGC_WORD_RST;
        if (i_reg_addr >= `EMGC_REG_AC0 && i_reg_addr <= `EMGC_REG_AC3) begin
            next_rdata = slot[emgc_ac_slot(i_reg_addr[1:0])];
        end
        unique case (i_reg_addr)
            `EMGC_REG_CTRL: next_rdata = ctrl;
            `EMGC_REG_STAT: begin
                next_rdata[`EMGC_STAT_ACTIVE] = o_emu_active;
                next_rdata[`EMGC_STAT_UNSUP]  = unsup_seen;
                next_rdata[`EMGC_STAT_IO]     = o_mem_io;
                next_rdata[`EMGC_STAT_IDLE]   = state == S_IDLE;
            end
            `EMGC_REG_PC:    next_rdata = pc;
            `EMGC_REG_CARRY: next_rdata = {15'h0000, carry};
            `EMGC_REG_MPC:   next_rdata = 16'(task_micro_address[ctrl[`EMGC_CTRL_SEL]]);
            default: ;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_reg_rdata <= `EMGC_WORD_RST;
        end else if (i_ce) begin
            o_reg_rdata <= i_reg_rd ? next_rdata : `EMGC_WORD_RST;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    chk_wake_always: assert property (
        ##1 o_emu_wake)
        else $error("emulator wakeup request dropped");

    chk_preempt_hold: assert property (
        i_ce && state == S_FETCH && preempt && !o_mem_rd |=> !o_mem_rd)
        else $error("fetch issued while another task wakes");

    chk_pc_advance: assert property (
        i_ce && finish && !do_jmp && !do_jsr |=>
        slot[`EMGC_PC_SLOT] == $past(pc) + 16'h0001)
        else $error("program counter did not advance by one");

    chk_load_target: assert property (
        i_ce && ld_done |=>
        slot[emgc_ac_slot($past(acc))] == $past(i_mem_rdata))
        else $error("loaded word not in target accumulator");

    chk_store_word: assert property (
        i_ce && state == S_EXEC && op == `EMGC_OP_STORE |=>
        o_mem_wr && !o_mem_rd && o_mem_addr == $past(ea) &&
        o_mem_wdata == $past(slot[emgc_ac_slot(acc)]))
        else $error("store wrong address or data");

    chk_call_link: assert property (
        i_ce && finish && do_jsr |=>
        slot[0] == $past(pc) + 16'h0001 && slot[`EMGC_PC_SLOT] == $past(ea))
        else $error("subroutine call link or target wrong");

    chk_io_region: assert property (
        o_mem_rd || o_mem_wr |->
        o_mem_io == (o_mem_addr >= `EMGC_IO_BASE) &&
        (!o_mem_io || o_mem_bank == '0))
        else $error("I/O region flag or bank wrong");

    chk_indirect_once: assert property (
        i_ce && state == S_INDIR_W && i_mem_ack |=>
        state == S_EXEC && ea == $past(i_mem_rdata) ##1 state != S_INDIR_W)
        else $error("indirection not taken exactly once");

    chk_mpc_reset: assert property (
        i_ce && i_reset_cycle |=>
        o_emu_mpc == '0 && task_micro_address[TASKS-1] == MPC_W'(TASKS-1))
        else $error("reset cycle did not load task numbers");

    chk_carry_kept: assert property (
        state != S_IDLE |=> carry == $past(carry))
        else $error("carry changed by a memory-group instruction");

    chk_page_zero: assert property (
        state == S_DECODE && instr[`EMGC_F_IDX_HI:`EMGC_F_IDX_LO] ==
        `EMGC_IDX_PAGE0 |-> eaif.ea == {8'h00, instr[7:0]})
        else $error("page zero location wrong");

    chk_widen_displacement_field: assert property (
        state == S_DECODE && instr[`EMGC_F_IDX_HI:`EMGC_F_IDX_LO] ==
        `EMGC_IDX_REL |-> eaif.ea == pc + (instr[7:0] > 8'h80 ?
        {8'hff, instr[7:0]} : {8'h00, instr[7:0]}))
        else $error("relative location widened wrongly");

    chk_ea_first: assert property (
        i_ce && state == S_DECODE |=> ea == $past(eaif.ea) &&
        slot[0] == $past(slot[0]))
        else $error("location not formed before state change");
endmodule // emgc_core

// [testbench/emgc_mem_model.sv]
// Purpose: Behavioural main memory on the far side of the core's memory port.
// Assumes: One request at a time, held by the core until acknowledged.
// Notes:   Latency steps through one to three cycles so that both prompt and
//          slow answers occur; idle read data inverts each cycle.
`timescale 1ns/10ps
module emgc_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [1:0]  i_bank,
    input  wire logic        i_io,
    output logic             o_ack,
    output logic [15:0]      o_rdata,
    output logic             o_io_seen,
    output logic             o_io_bad
);
    logic [15:0] m [0:65535];
    logic [1:0]  cnt;
    logic [1:0]  lat;

    initial begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        o_io_seen = 1'b0;
        o_io_bad = 1'b0;
        cnt = 2'h0;
        lat = 2'h0;
    end

    // Read data is only meaningful with the ack, so it never holds a value.
    always @(posedge i_clk_sys) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if ((i_rd || i_wr) && !o_ack) begin
            if (cnt == lat) begin
                o_ack <= 1'b1;
                cnt <= 2'h0;
                lat <= (lat == 2'h2) ? 2'h0 : lat + 2'h1;
                if (i_rd) o_rdata <= m[i_addr];
                if (i_wr) m[i_addr] <= i_wdata;
                if (i_io) o_io_seen <= 1'b1;
                if (i_io !== (i_addr >= 16'hfe00)) o_io_bad <= 1'b1;
                if (i_bank !== (i_io ? 2'h0 : 2'h1)) o_io_bad <= 1'b1;
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // emgc_mem_model

// [testbench/emulator_memory_group_core_bench.sv]
// Purpose: Self-checking bench of the emulator core with a memory model.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Expected read data are queued by the driver and checked by a
//          separate monitor when the answer cycle comes.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end

module emulator_memory_group_core_bench;
    import emgc_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, mem_rd, mem_wr, mem_ack;
    logic        mem_io, emu_wake, emu_active, reset_cycle, rd_q;
    logic        io_seen, io_bad, ce;
    logic [3:0]  reg_addr;
    logic [1:0]  mem_bank;
    logic [15:1] other_wake;
    logic [11:0] emu_mpc;
    emgc_word_t  reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
    emgc_word_t  r0, r1, d0, d1, d2, seed, e_mon;
    emgc_word_t  exp_q [$];
    int          fail_count = 0;
    int          compares = 0;
    localparam emgc_word_t P = 16'h0100;

    always #2 clk = ~clk;

    emgc_core dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_mem_rd(mem_rd),
        .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .o_mem_bank(mem_bank), .o_mem_io(mem_io), .i_mem_ack(mem_ack),
        .i_mem_rdata(mem_rdata), .i_other_wake(other_wake),
        .i_reset_cycle(reset_cycle), .o_emu_wake(emu_wake),
        .o_emu_active(emu_active), .o_emu_mpc(emu_mpc));

    emgc_mem_model mem (.i_clk_sys(clk), .i_rd(mem_rd), .i_wr(mem_wr),
        .i_addr(mem_addr), .i_wdata(mem_wdata), .i_bank(mem_bank),
        .i_io(mem_io), .o_ack(mem_ack), .o_rdata(mem_rdata),
        .o_io_seen(io_seen), .o_io_bad(io_bad));

    function automatic emgc_word_t lfsr(input emgc_word_t s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic emgc_word_t ins(input logic [1:0] op,
        input logic [1:0] ac, input logic ind, input logic [1:0] idx,
        input logic [7:0] displacement_field);
        return {1'b0, op, ac, ind, idx, displacement_field};
    endfunction

    task automatic wr(input logic [3:0] a, input emgc_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input emgc_word_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_idle;
        for (int n = 0; n < 200 && emu_active !== 1'b0; n++) @(posedge clk);
    endtask

    task automatic results;
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        rd_q <= reg_rd;
        if (rd_q) begin
            e_mon = exp_q.pop_front();
            `CHK(reg_rdata, e_mon)
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial begin
        int n;
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        other_wake = 15'h0000;
        reset_cycle = 1'b0;
        rd_q = 1'b0;
        seed = 16'h8366;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(emu_wake, 1'b1)
        `CHK(emu_mpc, 12'h000)
        rd(4'h2, 16'h0000);
        rd(4'h3, 16'h0000);
        @(posedge clk);
        reset_cycle <= 1'b1;
        @(posedge clk);
        reset_cycle <= 1'b0;
        for (int t = 0; t < 16; t++) begin
            wr(4'h0, {8'h00, 4'(t), 4'h0});
            rd(4'h8, 16'(t));
        end
        wr(4'h8, 16'h0abc);
        rd(4'h8, 16'h000f);
        rd(4'h9, 16'h0000);
        rd(4'hf, 16'h0000);
        seed = lfsr(seed); r0 = seed;
        seed = lfsr(seed); r1 = seed;
        seed = lfsr(seed); d0 = seed;
        seed = lfsr(seed); d1 = seed;
        seed = lfsr(seed); d2 = seed;
        wr(4'h4, r0);
        wr(4'h5, r1);
        wr(4'h6, 16'h2000);
        wr(4'h7, 16'h3000);
        wr(4'h3, 16'h0001);
        wr(4'h2, P);
        rd(4'h4, r0);
        rd(4'h5, r1);
        rd(4'h7, 16'h3000);
        rd(4'h2, P);
        // A write while the clock enable is low must leave the state alone.
        ce <= 1'b0;
        wr(4'h2, 16'h5555);
        ce <= 1'b1;
        rd(4'h2, P);
        mem.m[16'h0040] = d0;
        mem.m[16'h3080] = d1;
        mem.m[P + 16'h8] = 16'h0050;
        mem.m[16'h0050] = d2;
        mem.m[16'h0071] = 16'hfe10;
        mem.m[P] = ins(2'h1, 2'h1, 1'b0, 2'h0, 8'h40);
        mem.m[P + 16'h1] = ins(2'h2, 2'h1, 1'b0, 2'h2, 8'h81);
        mem.m[P + 16'h2] = ins(2'h1, 2'h0, 1'b0, 2'h3, 8'h80);
        mem.m[P + 16'h3] = ins(2'h1, 2'h2, 1'b1, 2'h1, 8'h05);
        mem.m[P + 16'h4] = ins(2'h2, 2'h0, 1'b0, 2'h0, 8'h60);
        mem.m[P + 16'h5] = ins(2'h0, 2'h1, 1'b0, 2'h3, 8'h02);
        mem.m[16'h3002] = ins(2'h2, 2'h3, 1'b0, 2'h0, 8'h70);
        mem.m[16'h3003] = ins(2'h2, 2'h0, 1'b1, 2'h0, 8'h71);
        mem.m[16'h3004] = {1'b1, seed[14:0]};
        mem.m[16'h3005] = ins(2'h0, 2'h0, 1'b0, 2'h1, 8'h00);
        wr(4'h0, 16'h0003);
        repeat (3) @(posedge clk);
        other_wake <= seed[15:1] | 15'h0001;
        wait_idle();
        `CHK(emu_active, 1'b0)
        repeat (8) begin
            @(posedge clk);
            `CHK({mem_rd, mem_wr}, 2'b00)
        end
        other_wake <= 15'h0000;
        wr(4'h2, 16'h7777);
        for (n = 0; n < 500 && !(mem_rd && mem_addr == 16'h3005); n++) begin
            @(posedge clk);
        end
        `CHK(mem_addr, 16'h3005)
        wr(4'h0, 16'h0002);
        wait_idle();
        `CHK(emu_active, 1'b0)
        rd(4'h4, d1);
        rd(4'h5, d0);
        rd(4'h6, d2);
        rd(4'h7, P + 16'h6);
        rd(4'h2, 16'h3005);
        rd(4'h3, 16'h0001);
        rd(4'h1, 16'h000a);
        wr(4'h1, 16'h0002);
        rd(4'h1, 16'h0008);
        `CHK(mem.m[16'h1f81], d0)
        `CHK(mem.m[16'h0060], d1)
        `CHK(mem.m[16'h0070], P + 16'h6)
        `CHK(mem.m[16'hfe10], d1)
        `CHK({io_seen, io_bad}, 2'b10)
        repeat (3) @(posedge clk);
        results();
    end
endmodule // emulator_memory_group_core_bench
